// file: common/nop_regs.svh
// constants for the otp and block protection host controller
`ifndef NOP_REGS_SVH
`define NOP_REGS_SVH

// apb register offsets
`define NOP_OFF_CTRL 8'h00
`define NOP_OFF_ADDR 8'h04
`define NOP_OFF_DATA 8'h08
`define NOP_OFF_STAT 8'h0c

// ctrl field positions
`define NOP_CTRL_OP_LSB 0
`define NOP_CTRL_GO 8
`define NOP_CTRL_WP 16

// operation codes written to ctrl
`define NOP_OP_OTP_ENTER 4'h1
`define NOP_OP_OTP_LOCK 4'h2
`define NOP_OP_OTP_EXIT 4'h3
`define NOP_OP_BP_SET 4'h4
`define NOP_OP_READ 4'h5
`define NOP_OP_RDOUT 4'h6
`define NOP_OP_PROG 4'h7
`define NOP_OP_RANDIN 4'h8
`define NOP_OP_CONFIRM 4'h9
`define NOP_OP_STATUS 4'ha

// flash command and feature bytes
`define NOP_CMD_SETF 8'hef
`define NOP_FA_MODE 8'h90
`define NOP_FA_BP 8'ha0
`define NOP_P1_NORM 8'h00
`define NOP_P1_OTP 8'h01
`define NOP_P1_LOCK 8'h03
`define NOP_P_ZERO 8'h00
`define NOP_CMD_READ 8'h00
`define NOP_CMD_READ_GO 8'h30
`define NOP_CMD_RDOUT 8'h05
`define NOP_CMD_RDOUT_GO 8'he0
`define NOP_CMD_PROG 8'h80
`define NOP_CMD_RANDIN 8'h85
`define NOP_CMD_PROG_GO 8'h10
`define NOP_CMD_STATUS 8'h70
`define NOP_STAT_PFAIL 8'h60

// otp page window and partial program budget
`define NOP_OTP_PG_MIN 6'h02
`define NOP_OTP_PG_MAX 6'h1f
`define NOP_OTP_NOP 4'h8

// timing, in ns, and derived clock counts (least times round up)
`define NOP_CLK_NS 10
`define NOP_T_ADL_NS 70
`define NOP_T_WB_NS 100
`define NOP_T_WW_NS 100
`define NOP_T_REA_NS 16
`define NOP_ADL_CYC ((`NOP_T_ADL_NS + `NOP_CLK_NS - 1) / `NOP_CLK_NS)
`define NOP_WB_CYC ((`NOP_T_WB_NS + `NOP_CLK_NS - 1) / `NOP_CLK_NS)
`define NOP_WW_CYC ((`NOP_T_WW_NS + `NOP_CLK_NS - 1) / `NOP_CLK_NS)
`define NOP_REA_CYC ((`NOP_T_REA_NS + `NOP_CLK_NS - 1) / `NOP_CLK_NS)

`endif

// file: common/nop_pkg.sv
// types for the otp and block protection host controller
package nop_pkg;
  typedef enum logic [2:0] {K_CMD, K_ADDR, K_WR, K_RDS, K_RDD, K_WAIT, K_END} nop_kind_t;
  typedef enum logic [1:0] {S_IDLE, S_WPH, S_RUN, S_ACK} nop_seq_t;
  typedef enum logic [2:0] {E_IDLE, E_SET, E_WLOW, E_RLOW, E_GAP, E_BUSY} nop_eng_t;
  typedef enum logic [1:0] {M_NORM, M_OTP, M_LOCK} nop_mode_t;
endpackage : nop_pkg

// file: common/nop_cyc_if.sv
// one flash bus cycle request between sequencer and pin engine
`timescale 1ns/10ps
interface nop_cyc_if;
  logic req;
  nop_pkg::nop_kind_t kind;
  logic [7:0] wbyte;
  logic ack;
  logic [7:0] rbyte;
  modport seq (output req, output kind, output wbyte, input ack, input rbyte);
  modport eng (input req, input kind, input wbyte, output ack, output rbyte);
endinterface : nop_cyc_if

// file: design/nop_engine.sv
// flash pin engine: one command, address, data or busy-wait cycle per request
`timescale 1ns/10ps
`include "nop_regs.svh"
module nop_engine (
  // system
  input wire logic clk,
  input wire logic rst,
  // sequencer side
  nop_cyc_if.eng cyc,
  // flash pins
  output logic cle,
  output logic ale,
  output logic we_n,
  output logic re_n,
  output logic [7:0] io_out,
  output logic io_oe,
  input wire logic [7:0] io_in,
  input wire logic ready_busy_n
);
  nop_pkg::nop_eng_t st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic cle_q, cle_d, ale_q, ale_d, we_n_q, we_n_d, re_n_q, re_n_d, oe_q, oe_d, ack_q, ack_d;
  logic [7:0] io_q, io_d, rb_q, rb_d;
  logic rd_q, rd_d;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    cle_d = cle_q;
    ale_d = ale_q;
    we_n_d = we_n_q;
    re_n_d = re_n_q;
    oe_d = oe_q;
    io_d = io_q;
    rb_d = rb_q;
    rd_d = rd_q;
    ack_d = 1'b0;
    case (st_q)
      nop_pkg::E_IDLE: begin
        // req is still high in the cycle that ack is seen; starting again would repeat the byte
        if (cyc.req && !ack_q) begin
          if (cyc.kind == nop_pkg::K_WAIT) begin
            // ready_busy_n is not valid until the busy window opens
            cnt_d = 4'(`NOP_WB_CYC);
            st_d = nop_pkg::E_BUSY;
          end else begin
            cle_d = (cyc.kind == nop_pkg::K_CMD);
            ale_d = (cyc.kind == nop_pkg::K_ADDR);
            rd_d = (cyc.kind == nop_pkg::K_RDS) || (cyc.kind == nop_pkg::K_RDD);
            oe_d = !rd_d;
            io_d = cyc.wbyte;
            st_d = nop_pkg::E_SET;
          end
        end
      end
      nop_pkg::E_SET: begin
        if (rd_q) begin
          re_n_d = 1'b0;
          cnt_d = 4'(`NOP_REA_CYC - 1);
          st_d = nop_pkg::E_RLOW;
        end else begin
          we_n_d = 1'b0;
          st_d = nop_pkg::E_WLOW;
        end
      end
      nop_pkg::E_WLOW: begin
        we_n_d = 1'b1;
        cnt_d = 4'(`NOP_ADL_CYC);
        st_d = nop_pkg::E_GAP;
      end
      nop_pkg::E_RLOW: begin
        if (cnt_q == 4'h0) begin
          re_n_d = 1'b1;
          rb_d = io_in;
          cnt_d = 4'(`NOP_ADL_CYC);
          st_d = nop_pkg::E_GAP;
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      nop_pkg::E_GAP: begin
        // gap covers address-to-data and read-to-write turnaround alike
        if (cnt_q == 4'h0) begin
          cle_d = 1'b0;
          ale_d = 1'b0;
          oe_d = 1'b0;
          ack_d = 1'b1;
          st_d = nop_pkg::E_IDLE;
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      nop_pkg::E_BUSY: begin
        if (cnt_q != 4'h0) begin
          cnt_d = cnt_q - 4'h1;
        end else if (ready_busy_n) begin
          ack_d = 1'b1;
          st_d = nop_pkg::E_IDLE;
        end
      end
      default: st_d = nop_pkg::E_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= nop_pkg::E_IDLE;
      cnt_q <= 4'h0;
      cle_q <= 1'b0;
      ale_q <= 1'b0;
      we_n_q <= 1'b1;
      re_n_q <= 1'b1;
      oe_q <= 1'b0;
      io_q <= 8'h00;
      rb_q <= 8'h00;
      rd_q <= 1'b0;
      ack_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      cle_q <= cle_d;
      ale_q <= ale_d;
      we_n_q <= we_n_d;
      re_n_q <= re_n_d;
      oe_q <= oe_d;
      io_q <= io_d;
      rb_q <= rb_d;
      rd_q <= rd_d;
      ack_q <= ack_d;
    end
  end

  assign cyc.ack = ack_q;
  assign cyc.rbyte = rb_q;
  assign cle = cle_q;
  assign ale = ale_q;
  assign we_n = we_n_q;
  assign re_n = re_n_q;
  assign io_out = io_q;
  assign io_oe = oe_q;
endmodule : nop_engine

// file: design/nop_host.sv
// host controller for flash otp area and block protection, apb programmed
//
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/10ps
`include "nop_regs.svh"
module nop_host (
  // system
  input wire logic clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // flash pins
  output logic ce_n,
  output logic cle,
  output logic ale,
  output logic we_n,
  output logic re_n,
  output logic wp_n,
  output logic [7:0] io_out,
  output logic io_oe,
  input wire logic [7:0] io_in,
  input wire logic ready_busy_n
);
  nop_cyc_if cyc ();

  nop_pkg::nop_seq_t st_q, st_d;
  nop_pkg::nop_mode_t mode_q, mode_d;
  nop_pkg::nop_kind_t kind_q, kind_d, sk;
  logic [7:0] sv;
  logic [3:0] op_q, op_d, cnt_q, cnt_d;
  logic [4:0] idx_q, idx_d, pg_q, pg_d;
  logic [15:0] col_q, col_d, row_q, row_d;
  logic [7:0] wdat_q, wdat_d, stat_q, stat_d, rdat_q, rdat_d, wbyte_q, wbyte_d;
  logic [5:0] bp_q, bp_d;
  logic req_q, req_d, wp_n_q, wp_n_d, ce_n_q, ce_n_d;
  logic locked_q, locked_d, solid_q, solid_d, open_q, open_d;
  logic refused_q, refused_d, pfail_q, pfail_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d;
  logic [3:0] nop_q [32];
  logic [3:0] nop_d [32];
  logic acc, wr_en, go, bad_pg, refuse, feat;
  logic [3:0] wop;

  // sequencer step table: kind and byte for op_q at idx_q
  always_comb begin
    sk = nop_pkg::K_END;
    sv = `NOP_P_ZERO;
    feat = (op_q == `NOP_OP_OTP_ENTER) || (op_q == `NOP_OP_OTP_LOCK) ||
           (op_q == `NOP_OP_OTP_EXIT) || (op_q == `NOP_OP_BP_SET);
    if (feat) begin
      case (idx_q)
        5'd0: begin sk = nop_pkg::K_CMD; sv = `NOP_CMD_SETF; end
        5'd1: begin
          sk = nop_pkg::K_ADDR;
          sv = (op_q == `NOP_OP_BP_SET) ? `NOP_FA_BP : `NOP_FA_MODE;
        end
        5'd2: begin
          sk = nop_pkg::K_WR;
          case (op_q)
            `NOP_OP_OTP_ENTER: sv = `NOP_P1_OTP;
            `NOP_OP_OTP_LOCK: sv = `NOP_P1_LOCK;
            `NOP_OP_BP_SET: sv = {2'b00, bp_q};
            default: sv = `NOP_P1_NORM;
          endcase
        end
        5'd3, 5'd4, 5'd5: sk = nop_pkg::K_WR;
        5'd6: sk = nop_pkg::K_WAIT;
        default: begin
          if (op_q == `NOP_OP_OTP_LOCK) begin
            // lock address cycles carry 00h, any value would do
            case (idx_q)
              5'd7: begin sk = nop_pkg::K_CMD; sv = `NOP_CMD_PROG; end
              5'd8, 5'd9, 5'd10, 5'd11: sk = nop_pkg::K_ADDR;
              5'd12: begin sk = nop_pkg::K_CMD; sv = `NOP_CMD_PROG_GO; end
              5'd13: sk = nop_pkg::K_WAIT;
              5'd14: begin sk = nop_pkg::K_CMD; sv = `NOP_CMD_STATUS; end
              5'd15: sk = nop_pkg::K_RDS;
              default: sk = nop_pkg::K_END;
            endcase
          end
        end
      endcase
    end else begin
      // read and program use the plain array sequences; no cache read exists
      case ({op_q, idx_q})
        {`NOP_OP_READ, 5'd0}: begin sk = nop_pkg::K_CMD; sv = `NOP_CMD_READ; end
        {`NOP_OP_READ, 5'd5}: begin sk = nop_pkg::K_CMD; sv = `NOP_CMD_READ_GO; end
        {`NOP_OP_READ, 5'd6}: sk = nop_pkg::K_WAIT;
        {`NOP_OP_READ, 5'd7}: sk = nop_pkg::K_RDD;
        {`NOP_OP_RDOUT, 5'd0}: begin sk = nop_pkg::K_CMD; sv = `NOP_CMD_RDOUT; end
        {`NOP_OP_RDOUT, 5'd3}: begin sk = nop_pkg::K_CMD; sv = `NOP_CMD_RDOUT_GO; end
        {`NOP_OP_RDOUT, 5'd4}: sk = nop_pkg::K_RDD;
        {`NOP_OP_PROG, 5'd0}: begin sk = nop_pkg::K_CMD; sv = `NOP_CMD_PROG; end
        {`NOP_OP_PROG, 5'd5}: begin sk = nop_pkg::K_WR; sv = wdat_q; end
        {`NOP_OP_RANDIN, 5'd0}: begin sk = nop_pkg::K_CMD; sv = `NOP_CMD_RANDIN; end
        {`NOP_OP_RANDIN, 5'd3}: begin sk = nop_pkg::K_WR; sv = wdat_q; end
        {`NOP_OP_CONFIRM, 5'd0}: begin sk = nop_pkg::K_CMD; sv = `NOP_CMD_PROG_GO; end
        {`NOP_OP_CONFIRM, 5'd1}: sk = nop_pkg::K_WAIT;
        {`NOP_OP_CONFIRM, 5'd2}, {`NOP_OP_STATUS, 5'd0}: begin
          sk = nop_pkg::K_CMD;
          sv = `NOP_CMD_STATUS;
        end
        {`NOP_OP_CONFIRM, 5'd3}, {`NOP_OP_STATUS, 5'd1}: sk = nop_pkg::K_RDS;
        default: begin
          // column then row address cycles for read and prog; column cycles only for rdout and randin
          if ((op_q == `NOP_OP_READ || op_q == `NOP_OP_PROG) && idx_q >= 5'd1 &&
              idx_q <= 5'd4) begin
            sk = nop_pkg::K_ADDR;
            case (idx_q)
              5'd1: sv = col_q[7:0];
              5'd2: sv = col_q[15:8];
              5'd3: sv = row_q[7:0];
              default: sv = row_q[15:8];
            endcase
          end else if ((op_q == `NOP_OP_RDOUT || op_q == `NOP_OP_RANDIN) &&
                       (idx_q == 5'd1 || idx_q == 5'd2)) begin
            sk = nop_pkg::K_ADDR;
            sv = (idx_q == 5'd1) ? col_q[7:0] : col_q[15:8];
          end
        end
      endcase
    end
  end

  // apb decode, go checks, sequencer and mode tracking
  always_comb begin
    st_d = st_q;
    mode_d = mode_q;
    kind_d = kind_q;
    op_d = op_q;
    cnt_d = cnt_q;
    idx_d = idx_q;
    pg_d = pg_q;
    col_d = col_q;
    row_d = row_q;
    wdat_d = wdat_q;
    bp_d = bp_q;
    stat_d = stat_q;
    rdat_d = rdat_q;
    wbyte_d = wbyte_q;
    req_d = req_q;
    wp_n_d = wp_n_q;
    locked_d = locked_q;
    solid_d = solid_q;
    open_d = open_q;
    refused_d = refused_q;
    pfail_d = pfail_q;
    nop_d = nop_q;
    acc = psel && penable && !pready_q;
    wr_en = psel && penable && pready_q && pwrite;
    pready_d = acc;
    pslverr_d = 1'b0;
    prdata_d = 32'h0000_0000;
    if (acc) begin
      case (paddr)
        `NOP_OFF_CTRL: prdata_d = {15'h0000, wp_n_q, 12'h000, op_q};
        `NOP_OFF_ADDR: prdata_d = {row_q, col_q};
        `NOP_OFF_DATA: prdata_d = {18'h00000, bp_q, wdat_q};
        `NOP_OFF_STAT: prdata_d = {8'h00, rdat_q, stat_q, 1'b0, pfail_q, refused_q,
                                   solid_q, locked_q, mode_q, st_q != nop_pkg::S_IDLE};
        default: pslverr_d = 1'b1;
      endcase
    end
    go = 1'b0;
    wop = pwdata[`NOP_CTRL_OP_LSB +: 4];
    if (wr_en) begin
      case (paddr)
        `NOP_OFF_CTRL: begin
          go = pwdata[`NOP_CTRL_GO];
          if (!go) begin
            wp_n_d = pwdata[`NOP_CTRL_WP];
          end
        end
        `NOP_OFF_ADDR: begin
          col_d = pwdata[15:0];
          row_d = pwdata[31:16];
        end
        `NOP_OFF_DATA: begin
          wdat_d = pwdata[7:0];
          bp_d = pwdata[13:8];
        end
        default: ;
      endcase
    end
    bad_pg = (row_q[15:6] != 10'h000) || (row_q[5:0] < `NOP_OTP_PG_MIN) ||
             (row_q[5:0] > `NOP_OTP_PG_MAX);
    refuse = (st_q != nop_pkg::S_IDLE) ||
             (mode_q == nop_pkg::M_OTP && bad_pg &&
              (wop == `NOP_OP_READ || wop == `NOP_OP_PROG)) ||
             (mode_q == nop_pkg::M_OTP && locked_q &&
              (wop == `NOP_OP_PROG || wop == `NOP_OP_RANDIN)) ||
             (!open_q && (wop == `NOP_OP_RANDIN || wop == `NOP_OP_CONFIRM)) ||
             (mode_q == nop_pkg::M_OTP && wop == `NOP_OP_CONFIRM &&
              nop_q[pg_q] >= `NOP_OTP_NOP) ||
             (solid_q && wop == `NOP_OP_BP_SET) ||
             (wop == 4'h0) || (wop > `NOP_OP_STATUS);
    case (st_q)
      nop_pkg::S_IDLE: begin
        if (go && refuse) begin
          refused_d = 1'b1;
        end else if (go) begin
          refused_d = 1'b0;
          op_d = wop;
          idx_d = 5'd0;
          if (wop == `NOP_OP_BP_SET) begin
            // protection writes are ignored unless write protect is released first
            wp_n_d = 1'b1;
            cnt_d = 4'(`NOP_WW_CYC);
            st_d = nop_pkg::S_WPH;
          end else begin
            st_d = nop_pkg::S_RUN;
          end
        end
      end
      nop_pkg::S_WPH: begin
        if (cnt_q == 4'h0) begin
          st_d = nop_pkg::S_RUN;
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      nop_pkg::S_RUN: begin
        if (sk == nop_pkg::K_END) begin
          st_d = nop_pkg::S_IDLE;
          case (op_q)
            `NOP_OP_OTP_ENTER: mode_d = nop_pkg::M_OTP;
            `NOP_OP_OTP_LOCK: begin
              mode_d = nop_pkg::M_LOCK;
              locked_d = 1'b1;
            end
            `NOP_OP_OTP_EXIT: mode_d = nop_pkg::M_NORM;
            `NOP_OP_BP_SET: solid_d = bp_q[0];
            `NOP_OP_PROG: begin
              open_d = 1'b1;
              pg_d = row_q[4:0];
            end
            `NOP_OP_CONFIRM: begin
              open_d = 1'b0;
              if (mode_q == nop_pkg::M_OTP) begin
                nop_d[pg_q] = nop_q[pg_q] + 4'h1;
              end
            end
            default: ;
          endcase
        end else begin
          req_d = 1'b1;
          kind_d = sk;
          wbyte_d = sv;
          st_d = nop_pkg::S_ACK;
        end
      end
      nop_pkg::S_ACK: begin
        if (cyc.ack) begin
          req_d = 1'b0;
          idx_d = idx_q + 5'd1;
          st_d = nop_pkg::S_RUN;
          if (kind_q == nop_pkg::K_RDS) begin
            stat_d = cyc.rbyte;
            pfail_d = (cyc.rbyte == `NOP_STAT_PFAIL);
          end else if (kind_q == nop_pkg::K_RDD) begin
            rdat_d = cyc.rbyte;
          end
        end
      end
      default: st_d = nop_pkg::S_IDLE;
    endcase
    // chip enable stays low across an open program so random input can follow
    ce_n_d = !((st_d != nop_pkg::S_IDLE) || open_d);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= nop_pkg::S_IDLE;
      mode_q <= nop_pkg::M_NORM;
      kind_q <= nop_pkg::K_END;
      op_q <= 4'h0;
      cnt_q <= 4'h0;
      idx_q <= 5'd0;
      pg_q <= 5'd0;
      col_q <= 16'h0000;
      row_q <= 16'h0000;
      wdat_q <= 8'h00;
      bp_q <= 6'h38;
      stat_q <= 8'h00;
      rdat_q <= 8'h00;
      wbyte_q <= 8'h00;
      req_q <= 1'b0;
      wp_n_q <= 1'b0;
      ce_n_q <= 1'b1;
      locked_q <= 1'b0;
      solid_q <= 1'b0;
      open_q <= 1'b0;
      refused_q <= 1'b0;
      pfail_q <= 1'b0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      for (int i = 0; i < 32; i++) begin
        nop_q[i] <= 4'h0;
      end
    end else begin
      st_q <= st_d;
      mode_q <= mode_d;
      kind_q <= kind_d;
      op_q <= op_d;
      cnt_q <= cnt_d;
      idx_q <= idx_d;
      pg_q <= pg_d;
      col_q <= col_d;
      row_q <= row_d;
      wdat_q <= wdat_d;
      bp_q <= bp_d;
      stat_q <= stat_d;
      rdat_q <= rdat_d;
      wbyte_q <= wbyte_d;
      req_q <= req_d;
      wp_n_q <= wp_n_d;
      ce_n_q <= ce_n_d;
      locked_q <= locked_d;
      solid_q <= solid_d;
      open_q <= open_d;
      refused_q <= refused_d;
      pfail_q <= pfail_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
      nop_q <= nop_d;
    end
  end

  assign cyc.req = req_q;
  assign cyc.kind = kind_q;
  assign cyc.wbyte = wbyte_q;
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign ce_n = ce_n_q;
  assign wp_n = wp_n_q;

  nop_engine u_engine (
    .clk(clk),
    .rst(rst),
    .cyc(cyc.eng),
    .cle(cle),
    .ale(ale),
    .we_n(we_n),
    .re_n(re_n),
    .io_out(io_out),
    .io_oe(io_oe),
    .io_in(io_in),
    .ready_busy_n(ready_busy_n)
  );
endmodule : nop_host

// file: verification/nop_host_asserts.sv
// port-level assertions for the otp and block protection host controller
`timescale 1ns/10ps
module nop_host_asserts (
  // system
  input wire logic clk,
  input wire logic rst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // flash pins
  input wire logic ce_n,
  input wire logic cle,
  input wire logic ale,
  input wire logic we_n,
  input wire logic re_n,
  input wire logic wp_n,
  input wire logic [7:0] io_out,
  input wire logic io_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // last command byte, so a feature address can be told from a column byte
  logic [7:0] cmd_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) cmd_q <= 8'h00;
    else if (cle && !we_n) cmd_q <= io_out;
  end
  a_ready_wait: assert property (psel && penable && !$past(penable) |=> pready)
    else $error("pready not one cycle after access start");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
  a_err_map: assert property (pready |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0c}))
    else $error("pslverr does not match address map");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("prdata not zero");
  a_we_pulse: assert property (!we_n |=> we_n) else $error("we_n low too long");
  a_re_pulse: assert property ($fell(re_n) |=> !re_n ##1 re_n) else $error("re_n pulse width");
  a_drive_sel: assert property (!we_n |-> !ce_n && io_oe && !(cle && ale))
    else $error("write strobe without drive");
  a_read_float: assert property (!re_n |-> !io_oe && !ce_n && we_n) else $error("read while driving");
  a_bp_wp: assert property (ale && !we_n && cmd_q == 8'hef && io_out == 8'ha0 |-> wp_n)
    else $error("protection write with wp_n low");
  a_confirm_wait: assert property (cle && !we_n && io_out == 8'h10 |=> (we_n && re_n)[*8])
    else $error("strobe right after confirm");
  c_confirm: cover property (cle && !we_n && io_out == 8'h10);
  c_bp_write: cover property (ale && !we_n && cmd_q == 8'hef && io_out == 8'ha0);
  c_slverr: cover property (pready && pslverr);
endmodule : nop_host_asserts
bind nop_host nop_host_asserts nop_host_asserts_i (.clk(clk), .rst(rst), .psel(psel),
  .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n), .re_n(re_n), .wp_n(wp_n), .io_out(io_out),
  .io_oe(io_oe));

// file: verification/nop_flash_model.sv
// behavioural flash device: feature access, otp area and block protection
`timescale 1ns/10ps
module nop_flash_model #(
  parameter bit STRAP = 1'b1
) (
  // flash pins
  input wire logic ce_n,
  input wire logic cle,
  input wire logic ale,
  input wire logic we_n,
  input wire logic re_n,
  input wire logic wp_n,
  input wire logic [7:0] io_out,
  // device answers
  output logic [7:0] io_in,
  output logic ready_busy_n
);
  logic [7:0] cmd_q, fa_q, mode_q, stat_q;
  logic [5:0] bp_q;
  logic [15:0] col_q, row_q;
  logic lock_q, fail;
  int acnt, pcnt, busy_ns;
  function automatic logic hit(input logic [9:0] b);
    int sz;
    sz = 16 << (bp_q[5:3] - 1);
    if (bp_q[5:3] == 3'h0) return 1'b0;
    if (bp_q[5:3] == 3'h7) return 1'b1;
    if (bp_q[1] && bp_q[5:3] == 3'h6) return b == 10'h0;
    return bp_q[1] ^ (bp_q[2] ? b < sz : b >= 1024 - sz);
  endfunction : hit
  initial begin
    io_in = 8'h00;
    ready_busy_n = 1'b1;
    mode_q = 8'h00;
    lock_q = 1'b0;
    cmd_q = 8'h00;
    bp_q = STRAP ? 6'b111000 : 6'b000000;
  end
  always @(negedge ready_busy_n) #(busy_ns) ready_busy_n = 1'b1;
  always @(posedge we_n) if (!ce_n) begin
    if (cle) begin
      cmd_q = io_out;
      acnt = 0;
      pcnt = 0;
      busy_ns = 500;
      if (io_out == 8'h30) ready_busy_n = 1'b0;
      if (io_out == 8'h10) begin
        // lock takes any address value: the whole area goes read-only
        if (mode_q == 8'h03) lock_q = 1'b1;
        fail = (mode_q == 8'h00 && hit(row_q[15:6])) || (mode_q == 8'h01 && lock_q);
        stat_q = fail ? 8'h60 : 8'he0;
        busy_ns = (mode_q == 8'h01 && lock_q) ? 5000 : fail ? 2000 : 3000;
        ready_busy_n = 1'b0;
      end
    end else if (ale) begin
      if (cmd_q == 8'hef) fa_q = io_out;
      else if (acnt < 2) col_q = {io_out, col_q[15:8]};
      else row_q = {io_out, row_q[15:8]};
      acnt = acnt + 1;
    end else if (cmd_q == 8'hef) begin
      if (pcnt == 0 && fa_q == 8'h90) mode_q = io_out;
      if (pcnt == 0 && fa_q == 8'ha0 && STRAP && wp_n && !bp_q[0]) begin
        bp_q = io_out[5:0];
      end
      if (pcnt == 3) ready_busy_n = 1'b0;
      pcnt = pcnt + 1;
    end
  end
  always @(negedge re_n) io_in <= #16 (cmd_q == 8'h70) ? stat_q :
    row_q[7:0] + col_q[7:0] + (mode_q == 8'h01 ? 8'h80 : 8'h00);
  // released bus shows the inverse so a stale sample cannot pass
  always @(posedge re_n) io_in <= #15 ~io_in;
endmodule : nop_flash_model

// file: verification/nop_host_tb.sv
// self-checking bench for the otp and block protection host controller
`timescale 1ns/10ps
module nop_host_tb;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, err_q;
  logic ce_n, cle, ale, we_n, re_n, wp_n, io_oe, ready_busy_n;
  logic [7:0] paddr, io_out, io_in;
  logic [31:0] pwdata, prdata, rd;
  int errors, compares;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  nop_host nop_host_i (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n), .re_n(re_n), .wp_n(wp_n),
    .io_out(io_out), .io_oe(io_oe), .io_in(io_in), .ready_busy_n(ready_busy_n));
  nop_flash_model #(.STRAP(1'b1)) nop_flash_model_i (.ce_n(ce_n), .cle(cle), .ale(ale),
    .we_n(we_n), .re_n(re_n), .wp_n(wp_n), .io_out(io_out), .io_in(io_in),
    .ready_busy_n(ready_busy_n));
  task finish_test;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : finish_test
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      finish_test();
    end
    rd = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // runs one operation and leaves the settled status word in rd
  task go(input logic [3:0] op, input logic [31:0] a, input logic [31:0] d);
    int n;
    apb(1'b1, 8'h04, a);
    apb(1'b1, 8'h08, d);
    apb(1'b1, 8'h00, {23'h0, 1'b1, 4'h0, op});
    n = 0;
    do begin
      apb(1'b0, 8'h0c, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 3000);
    if (n >= 3000) begin
      errors++;
      finish_test();
    end
  endtask : go
  task prog_blk(input logic [9:0] b, input logic f);
    go(4'h7, {b, 22'h0}, 32'h5a);
    go(4'h9, 32'h0, 32'h0);
    chk("protect fail", f, rd[6]);
    chk("status", f ? 8'h60 : 8'he0, rd[15:8]);
  endtask : prog_blk
  task bp_case(input logic [5:0] p, input logic [9:0] b, input logic f);
    go(4'h4, 32'h0, {18'h0, p, 8'h00});
    prog_blk(b, f);
  endtask : bp_case
  task t_regs;
    apb(1'b0, 8'h08, 32'h0);
    chk("data reset", 32'h00003800, rd);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped", 1'b1, err_q);
    apb(1'b1, 8'h00, 32'h00010000);
    // the pin changes on the edge that completes the write; sample it one edge later
    @(posedge clk);
    chk("wp pin", 1'b1, wp_n);
  endtask : t_regs
  task t_bp;
    prog_blk(10'd1000, 1'b1);
    bp_case(6'b000000, 10'd1023, 1'b0);
    bp_case(6'b001000, 10'd1010, 1'b1);
    prog_blk(10'd5, 1'b0);
    bp_case(6'b110100, 10'd511, 1'b1);
    prog_blk(10'd512, 1'b0);
    bp_case(6'b110010, 10'd0, 1'b1);
    prog_blk(10'd1, 1'b0);
    bp_case(6'b010110, 10'd31, 1'b0);
    prog_blk(10'd32, 1'b1);
    bp_case(6'b111110, 10'd3, 1'b1);
  endtask : t_bp
  task t_solid;
    go(4'h4, 32'h0, {18'h0, 6'b000001, 8'h00});
    chk("solid", 1'b1, rd[4]);
    go(4'h4, 32'h0, {18'h0, 6'b111000, 8'h00});
    chk("refused", 1'b1, rd[5]);
    prog_blk(10'd7, 1'b0);
  endtask : t_solid
  task t_otp;
    go(4'h1, 32'h0, 32'h0);
    chk("mode", 2'h1, rd[2:1]);
    go(4'h5, {16'h5, 16'h3}, 32'h0);
    chk("otp read", 8'h88, rd[23:16]);
    go(4'h6, {16'h5, 16'h9}, 32'h0);
    chk("random out", 8'h8e, rd[23:16]);
    go(4'h5, {16'h0040, 16'h0}, 32'h0);
    chk("page range", 1'b1, rd[5]);
    go(4'h8, {16'h3, 16'h7}, 32'h0);
    chk("randin alone", 1'b1, rd[5]);
    for (int i = 0; i < 8; i++) begin
      go(4'h7, {16'h3, 16'h0}, 32'h11);
      if (i == 0) go(4'h8, {16'h3, 16'h7}, 32'h22);
      go(4'h9, 32'h0, 32'h0);
      chk("otp program", 2'h0, {rd[6], rd[5]});
    end
    go(4'h7, {16'h3, 16'h0}, 32'h11);
    go(4'h9, 32'h0, 32'h0);
    chk("ninth program", 1'b1, rd[5]);
    go(4'h3, 32'h0, 32'h0);
    chk("mode exit", 2'h0, rd[2:1]);
  endtask : t_otp
  task t_lock;
    go(4'h2, 32'h0, 32'h0);
    chk("otp locked", 1'b1, rd[3]);
    go(4'h1, 32'h0, 32'h0);
    go(4'h7, {16'h4, 16'h0}, 32'h33);
    chk("locked program", 1'b1, rd[5]);
    go(4'h3, 32'h0, 32'h0);
  endtask : t_lock
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    errors = 0;
    compares = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_bp();
    t_solid();
    t_otp();
    t_lock();
    finish_test();
  end
endmodule : nop_host_tb
